//--- pvd_pkg.sv
// constants, types and register map for the phy vendor diagnostic register bank
// Operation
// R1: count each 10 Mb/s receive rx10_frame_end_error_count error in a 16-bit counter.
// R2: rx10_frame_end_error_count error counter holds at maximum, never wraps.
// R3: count each transmit jabber detection in a 16-bit counter.
// R4: jabber counter holds at maximum once full.
// R5: reading a counter returns its value then clears it; both reset to zero.
// R6: equalizer word: opcode in bits 15:13, operand in bits 12:0.
// R7: opcodes 001, 010, 011 load operand into configuration registers 0, 1, 2.
// R8: opcode 100 reads detector status fields packed as documented.
// R9: config 0: bit 12 loads coded zero, bit 4 zero force, bits 7:6 squelch force.
// R10: config 0 bits 11:10 high threshold timing, bits 9:8 low threshold timing.
// R11: config 1 bits 8:7 select signal-detect preset, bit 6 loads it.
// R12: config 1 bits 10:9 ratio pair, bit 4 lock disable, bit 0 test mode.
// R13: config 2 bits 7:6 select slow-mode adaptation time.
// R14: config 2 bits 5:4 force signal detect, bits 1:0 disable thresholds, 9:8 misc.
// R15: opcode 101 reads a jitter slice chosen by operand bits 1:0.
// R16: opcode 110 reads a clock counter slice chosen by operand bit 0.
// R17: led select bits 2:0 choose both led pin sources.
// R18: opcode 000 is no operation, 111 reserved; neither changes configuration.
// R19: station writes zero to reserved operand and led select bits.
package pvd_pkg;
   localparam logic [4:0] ADDR_EOF_CNT = 5'h18;
   localparam logic [4:0] ADDR_JAB_CNT = 5'h19;
   localparam logic [4:0] ADDR_EQ = 5'h1A;
   localparam logic [4:0] ADDR_LED = 5'h1B;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [12:0] CFG_RST = 13'h0000;
   localparam logic [2:0] LED_RST = 3'h0;
   localparam logic [1:0] SLOW_RST = 2'h0;
   localparam logic [4:0] SD_PRE0 = 5'h10;
   localparam logic [4:0] SD_PRE1 = 5'h18;
   localparam logic [4:0] SD_PRE2 = 5'h1C;
   localparam logic [4:0] SD_PRE3 = 5'h1F;
   localparam logic [2:0] OP_NOP = 3'h0;
   localparam logic [2:0] OP_CFG0 = 3'h1;
   localparam logic [2:0] OP_CFG1 = 3'h2;
   localparam logic [2:0] OP_CFG2 = 3'h3;
   localparam logic [2:0] OP_STAT = 3'h4;
   localparam logic [2:0] OP_JIT = 3'h5;
   localparam logic [2:0] OP_CLK = 3'h6;
   localparam logic [2:0] OP_RSV = 3'h7;
   // led pin sources
   typedef enum logic [1:0] {
      PVD_SRC_OFF = 2'b00,
      PVD_SRC_ON = 2'b01,
      PVD_SRC_A = 2'b10,
      PVD_SRC_B = 2'b11
   } pvd_src_t;
   // config register 0 view
   typedef struct packed {
      logic set_zero;
      logic [1:0] hi_thr;
      logic [1:0] lo_thr;
      logic sq_force_en;
      logic sq_force_val;
      logic rsv5;
      logic zero_force_en;
      logic [3:0] coded_zero;
   } pvd_cfg0_t;
   typedef struct packed {
      logic [1:0] rsv;
      logic [1:0] ratio_sel;
      logic [1:0] sd_preset_sel;
      logic sd_load;
      logic rsv5;
      logic lock_dis;
      logic [2:0] rsv3;
      logic test_mode;
   } pvd_cfg1_t;
   typedef struct packed {
      logic [2:0] rsv;
      logic breakdown;
      logic det_sel;
      logic [1:0] slow_time;
      logic sd_force_en;
      logic sd_force_val;
      logic [1:0] rsv2;
      logic hi_sd_dis;
      logic lo_sd_dis;
   } pvd_cfg2_t;
   // live detector state into the bank
   typedef struct packed {
      logic [1:0] fsm_state;
      logic lock_adapt;
      logic sig_detect;
      logic squelch;
      logic [3:0] coded_zero;
      logic [26:0] jitter;
      logic [23:0] clk_count;
   } pvd_det_t;
   // led event sources
   typedef struct packed {
      logic activity;
      logic link;
      logic speed;
      logic collision;
   } pvd_led_in_t;
endpackage : pvd_pkg

//--- pvd_regs.sv
// vendor diagnostic registers: event counters, equalizer command, led select
`timescale 1ns/100ps
module pvd_regs (
   input wire logic clk_sys, // 125 MHz clock
   input wire logic arst_n, // async reset, active low
   input wire logic [4:0] addr, // register address
   input wire logic [15:0] wdata, // write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   output logic [15:0] rdata, // read data, cycle after rd
   input wire logic eof_err_evt, // 10 Mb/s rx10_frame_end_error_count error pulse
   input wire logic jabber_evt, // jabber detection pulse
   input wire pvd_pkg::pvd_det_t det, // detector state
   input wire pvd_pkg::pvd_led_in_t led_in, // led event sources
   output pvd_pkg::pvd_cfg0_t cfg0, // adaptive_detect_unit config 0
   output pvd_pkg::pvd_cfg1_t cfg1, // adaptive_detect_unit config 1
   output pvd_pkg::pvd_cfg2_t cfg2, // adaptive_detect_unit config 2
   output logic cfg0_load_pulse, // coded zero load command
   output logic sd_load_pulse, // signal-detect preset load command
   output logic [4:0] sd_preset, // selected signal-detect preset
   output logic activity_led_n, // activity_led_pin, active low
   output logic link_led_n // link_led_pin, active low
);
   logic [15:0] eof_cnt_r;
   logic [15:0] jab_cnt_r;
   logic [2:0] opcode_r;
   logic [12:0] operand_r;
   logic [2:0] led_sel_r;
   logic rd_eof, rd_jab, wr_eq;
   logic [15:0] status_word;
   logic [15:0] eq_read;

   assign rd_eof = rd && (addr == pvd_pkg::ADDR_EOF_CNT);
   assign rd_jab = rd && (addr == pvd_pkg::ADDR_JAB_CNT);
   assign wr_eq = wr && (addr == pvd_pkg::ADDR_EQ);

   // an event in the clearing read cycle starts the new count at one
   function automatic logic [15:0] cnt_next(input logic [15:0] c, input logic evt, input logic clr);
      logic [15:0] base;
      base = clr ? pvd_pkg::CNT_RST : c;
      if (evt && base != pvd_pkg::CNT_MAX) begin
         cnt_next = base + 16'h0001;
      end else begin
         cnt_next = base;
      end
   endfunction : cnt_next

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         eof_cnt_r <= pvd_pkg::CNT_RST; // see R5
      end else begin
         eof_cnt_r <= cnt_next(eof_cnt_r, eof_err_evt, rd_eof); // see R1 see R2 see R5
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         jab_cnt_r <= pvd_pkg::CNT_RST;
      end else begin
         jab_cnt_r <= cnt_next(jab_cnt_r, jabber_evt, rd_jab); // see R3 see R4 see R5
      end
   end

   // last command word; opcode selects what reads return
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         opcode_r <= pvd_pkg::OP_NOP;
         operand_r <= pvd_pkg::CFG_RST;
      end else if (wr_eq) begin
         opcode_r <= wdata[15:13]; // see R6
         operand_r <= wdata[12:0];
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cfg0 <= pvd_pkg::CFG_RST;
         cfg1 <= pvd_pkg::CFG_RST;
         cfg2 <= {3'h0, 2'h0, pvd_pkg::SLOW_RST, 6'h00}; // see R13
      end else if (wr_eq) begin
         unique case (wdata[15:13])
            pvd_pkg::OP_CFG0: cfg0 <= wdata[12:0]; // see R7 see R9 see R10
            pvd_pkg::OP_CFG1: cfg1 <= wdata[12:0]; // see R7 see R11 see R12
            pvd_pkg::OP_CFG2: cfg2 <= wdata[12:0]; // see R7 see R13 see R14
            default: begin
               // nop, reads and reserved leave configuration alone
            end // see R18
         endcase
      end
   end

   // load commands act once, on the write that carries them
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cfg0_load_pulse <= 1'b0;
         sd_load_pulse <= 1'b0;
      end else begin
         cfg0_load_pulse <= wr_eq && wdata[15:13] == pvd_pkg::OP_CFG0 && wdata[12]; // see R9
         sd_load_pulse <= wr_eq && wdata[15:13] == pvd_pkg::OP_CFG1 && wdata[6]; // see R11
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sd_preset <= pvd_pkg::SD_PRE0;
      end else begin
         unique case (cfg1.sd_preset_sel)
            2'b00: sd_preset <= pvd_pkg::SD_PRE0; // see R11
            2'b01: sd_preset <= pvd_pkg::SD_PRE1;
            2'b10: sd_preset <= pvd_pkg::SD_PRE2;
            2'b11: sd_preset <= pvd_pkg::SD_PRE3;
         endcase
      end
   end

   always_comb begin
      status_word = {2'b00, opcode_r, cfg1.ratio_sel, det.fsm_state, det.lock_adapt,
                     det.sig_detect, det.squelch, det.coded_zero}; // see R8
      unique case (opcode_r)
         pvd_pkg::OP_STAT: eq_read = status_word;
         pvd_pkg::OP_JIT: begin
            if (operand_r[1]) begin
               eq_read = det.jitter[26:11]; // see R15
            end else if (operand_r[0]) begin
               eq_read = det.jitter[21:6];
            end else begin
               eq_read = det.jitter[15:0];
            end
         end
         pvd_pkg::OP_CLK: eq_read = operand_r[0] ? det.clk_count[23:8] : det.clk_count[15:0]; // see R16
         default: eq_read = {opcode_r, operand_r};
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rdata <= 16'h0000;
      end else if (rd) begin
         unique case (addr)
            pvd_pkg::ADDR_EOF_CNT: rdata <= eof_cnt_r; // see R5
            pvd_pkg::ADDR_JAB_CNT: rdata <= jab_cnt_r;
            pvd_pkg::ADDR_EQ: rdata <= eq_read;
            pvd_pkg::ADDR_LED: rdata <= {13'h0000, led_sel_r};
            default: rdata <= 16'h0000;
         endcase
      end else begin
         rdata <= 16'h0000;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         led_sel_r <= pvd_pkg::LED_RST;
      end else if (wr && addr == pvd_pkg::ADDR_LED) begin
         led_sel_r <= wdata[2:0]; // see R17
      end
   end

   // led pins are active low: a lit led drives the pin low
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         activity_led_n <= 1'b1;
         link_led_n <= 1'b1;
      end else begin
         unique case (led_sel_r)
            3'b000: begin
               activity_led_n <= ~led_in.activity; // see R17
               link_led_n <= ~led_in.link;
            end
            3'b001: begin
               activity_led_n <= ~led_in.speed;
               link_led_n <= ~led_in.collision;
            end
            3'b010: begin
               activity_led_n <= ~led_in.speed;
               link_led_n <= ~led_in.link;
            end
            3'b011: begin
               activity_led_n <= ~led_in.activity;
               link_led_n <= ~led_in.collision;
            end
            3'b100: begin
               activity_led_n <= 1'b1;
               link_led_n <= 1'b1;
            end
            3'b101: begin
               activity_led_n <= 1'b1;
               link_led_n <= 1'b0;
            end
            3'b110: begin
               activity_led_n <= 1'b0;
               link_led_n <= 1'b1;
            end
            3'b111: begin
               activity_led_n <= 1'b0;
               link_led_n <= 1'b0;
            end
         endcase
      end
   end

   property p_eof_sat;
      @(posedge clk_sys) disable iff (!arst_n)
      (eof_cnt_r == pvd_pkg::CNT_MAX && !rd_eof) |=> eof_cnt_r == pvd_pkg::CNT_MAX;
   endproperty
   a_eof_sat: assert property (p_eof_sat) else $error("eof counter left max"); // see R2
   property p_eof_inc;
      @(posedge clk_sys) disable iff (!arst_n)
      (eof_err_evt && !rd_eof && eof_cnt_r != pvd_pkg::CNT_MAX) |=> eof_cnt_r == $past(eof_cnt_r) + 16'h0001;
   endproperty
   a_eof_inc: assert property (p_eof_inc) else $error("eof counter missed event"); // see R1
   property p_jab_sat;
      @(posedge clk_sys) disable iff (!arst_n)
      (jab_cnt_r == pvd_pkg::CNT_MAX && !rd_jab) |=> jab_cnt_r == pvd_pkg::CNT_MAX;
   endproperty
   a_jab_sat: assert property (p_jab_sat) else $error("jabber counter left max"); // see R4
   property p_jab_inc;
      @(posedge clk_sys) disable iff (!arst_n)
      (jabber_evt && !rd_jab && jab_cnt_r != pvd_pkg::CNT_MAX) |=> jab_cnt_r == $past(jab_cnt_r) + 16'h0001;
   endproperty
   a_jab_inc: assert property (p_jab_inc) else $error("jabber counter missed event"); // see R3
   property p_rc;
      @(posedge clk_sys) disable iff (!arst_n)
      rd_eof |=> (rdata == $past(eof_cnt_r)) && (eof_cnt_r == {15'h0000, $past(eof_err_evt)});
   endproperty
   a_rc: assert property (p_rc) else $error("read-clear wrong"); // see R5
   property p_cfg0;
      @(posedge clk_sys) disable iff (!arst_n)
      (wr_eq && wdata[15:13] == pvd_pkg::OP_CFG0) |=> cfg0 == $past(wdata[12:0]);
   endproperty
   a_cfg0: assert property (p_cfg0) else $error("cfg0 not loaded"); // see R7
   property p_nop;
      @(posedge clk_sys) disable iff (!arst_n)
      (wr_eq && (wdata[15:13] == pvd_pkg::OP_NOP || wdata[15:13] == pvd_pkg::OP_RSV))
         |=> $stable(cfg0) && $stable(cfg1) && $stable(cfg2);
   endproperty
   a_nop: assert property (p_nop) else $error("nop changed config"); // see R18
   property p_led_on;
      @(posedge clk_sys) disable iff (!arst_n)
      (led_sel_r == 3'b111) ##1 (led_sel_r == 3'b111) |-> !activity_led_n && !link_led_n;
   endproperty
   a_led_on: assert property (p_led_on) else $error("leds not both on"); // see R17
   property p_clk_win;
      @(posedge clk_sys) disable iff (!arst_n)
      (rd && addr == pvd_pkg::ADDR_EQ && opcode_r == pvd_pkg::OP_CLK && operand_r[0]) |=> rdata == $past(det.clk_count[23:8]);
   endproperty
   a_clk_win: assert property (p_clk_win) else $error("clock window wrong"); // see R16

   property p_jab_rc;
      @(posedge clk_sys) disable iff (!arst_n)
      rd_jab |=> (rdata == $past(jab_cnt_r)) && (jab_cnt_r == {15'h0000, $past(jabber_evt)});
   endproperty
   a_jab_rc: assert property (p_jab_rc) else $error("jabber read-clear wrong"); // see R5

   property p_cfg1;
      @(posedge clk_sys) disable iff (!arst_n)
      (wr_eq && wdata[15:13] == pvd_pkg::OP_CFG1) |=> cfg1 == $past(wdata[12:0]);
   endproperty
   a_cfg1: assert property (p_cfg1) else $error("cfg1 not loaded"); // see R7

   property p_cfg2;
      @(posedge clk_sys) disable iff (!arst_n)
      (wr_eq && wdata[15:13] == pvd_pkg::OP_CFG2) |=> cfg2 == $past(wdata[12:0]);
   endproperty
   a_cfg2: assert property (p_cfg2) else $error("cfg2 not loaded"); // see R7

   property p_cz_load;
      @(posedge clk_sys) disable iff (!arst_n)
      (wr_eq && wdata[15:13] == pvd_pkg::OP_CFG0 && wdata[12]) |=> cfg0_load_pulse;
   endproperty
   a_cz_load: assert property (p_cz_load) else $error("coded zero load missing"); // see R9

   property p_load_idle;
      @(posedge clk_sys) disable iff (!arst_n)
      !wr_eq |=> !cfg0_load_pulse && !sd_load_pulse;
   endproperty
   a_load_idle: assert property (p_load_idle) else $error("load pulse without write"); // see R9

   property p_sd_load;
      @(posedge clk_sys) disable iff (!arst_n)
      (wr_eq && wdata[15:13] == pvd_pkg::OP_CFG1 && wdata[6]) |=> sd_load_pulse;
   endproperty
   a_sd_load: assert property (p_sd_load) else $error("preset load missing"); // see R11

   property p_sd_pre3;
      @(posedge clk_sys) disable iff (!arst_n)
      cfg1.sd_preset_sel == 2'b11 |=> sd_preset == pvd_pkg::SD_PRE3;
   endproperty
   a_sd_pre3: assert property (p_sd_pre3) else $error("preset 3 wrong"); // see R11

   property p_sd_pre0;
      @(posedge clk_sys) disable iff (!arst_n)
      cfg1.sd_preset_sel == 2'b00 |=> sd_preset == pvd_pkg::SD_PRE0;
   endproperty
   a_sd_pre0: assert property (p_sd_pre0) else $error("preset 0 wrong"); // see R11

   property p_opcode;
      @(posedge clk_sys) disable iff (!arst_n)
      wr_eq |=> opcode_r == $past(wdata[15:13]);
   endproperty
   a_opcode: assert property (p_opcode) else $error("opcode not kept"); // see R6

   property p_stat;
      @(posedge clk_sys) disable iff (!arst_n)
      (rd && addr == pvd_pkg::ADDR_EQ && opcode_r == pvd_pkg::OP_STAT)
         |=> rdata[15:11] == {2'b00, pvd_pkg::OP_STAT} && rdata[3:0] == $past(det.coded_zero);
   endproperty
   a_stat: assert property (p_stat) else $error("status word wrong"); // see R8

   property p_jit0;
      @(posedge clk_sys) disable iff (!arst_n)
      (rd && addr == pvd_pkg::ADDR_EQ && opcode_r == pvd_pkg::OP_JIT && operand_r[1:0] == 2'b00)
         |=> rdata == $past(det.jitter[15:0]);
   endproperty
   a_jit0: assert property (p_jit0) else $error("jitter low slice wrong"); // see R15

   property p_jit1;
      @(posedge clk_sys) disable iff (!arst_n)
      (rd && addr == pvd_pkg::ADDR_EQ && opcode_r == pvd_pkg::OP_JIT && operand_r[1:0] == 2'b01)
         |=> rdata == $past(det.jitter[21:6]);
   endproperty
   a_jit1: assert property (p_jit1) else $error("jitter mid slice wrong"); // see R15

   property p_jit2;
      @(posedge clk_sys) disable iff (!arst_n)
      (rd && addr == pvd_pkg::ADDR_EQ && opcode_r == pvd_pkg::OP_JIT && operand_r[1])
         |=> rdata == $past(det.jitter[26:11]);
   endproperty
   a_jit2: assert property (p_jit2) else $error("jitter high slice wrong"); // see R15

   property p_clk0;
      @(posedge clk_sys) disable iff (!arst_n)
      (rd && addr == pvd_pkg::ADDR_EQ && opcode_r == pvd_pkg::OP_CLK && !operand_r[0])
         |=> rdata == $past(det.clk_count[15:0]);
   endproperty
   a_clk0: assert property (p_clk0) else $error("clock low window wrong"); // see R16

   property p_led_off;
      @(posedge clk_sys) disable iff (!arst_n)
      (led_sel_r == 3'b100) ##1 (led_sel_r == 3'b100) |-> activity_led_n && link_led_n;
   endproperty
   a_led_off: assert property (p_led_off) else $error("leds not both off"); // see R17

   property p_led_sel;
      @(posedge clk_sys) disable iff (!arst_n)
      (wr && addr == pvd_pkg::ADDR_LED) |=> led_sel_r == $past(wdata[2:0]);
   endproperty
   a_led_sel: assert property (p_led_sel) else $error("led select not loaded"); // see R17

   property p_rd_idle;
      @(posedge clk_sys) disable iff (!arst_n)
      !rd |=> rdata == 16'h0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot"); // see R5

   property p_eof_clr;
      @(posedge clk_sys) disable iff (!arst_n)
      (rd_eof && !eof_err_evt) |=> eof_cnt_r == pvd_pkg::CNT_RST;
   endproperty
   a_eof_clr: assert property (p_eof_clr) else $error("eof counter not cleared"); // see R5

   property p_jab_clr;
      @(posedge clk_sys) disable iff (!arst_n)
      (rd_jab && !jabber_evt) |=> jab_cnt_r == pvd_pkg::CNT_RST;
   endproperty
   a_jab_clr: assert property (p_jab_clr) else $error("jabber counter not cleared"); // see R5

   property p_cnt_wr;
      @(posedge clk_sys) disable iff (!arst_n)
      (wr && addr == pvd_pkg::ADDR_JAB_CNT && !jabber_evt) |=> $stable(jab_cnt_r);
   endproperty
   a_cnt_wr: assert property (p_cnt_wr) else $error("counter took a write"); // see R5

   property p_led_act;
      @(posedge clk_sys) disable iff (!arst_n)
      led_sel_r == 3'b000 |=> activity_led_n == !$past(led_in.activity);
   endproperty
   a_led_act: assert property (p_led_act) else $error("activity led wrong"); // see R17

   property p_led_col;
      @(posedge clk_sys) disable iff (!arst_n)
      led_sel_r == 3'b001 |=> link_led_n == !$past(led_in.collision);
   endproperty
   a_led_col: assert property (p_led_col) else $error("collision led wrong"); // see R17
   c_eof_sat: cover property (@(posedge clk_sys) disable iff (!arst_n) eof_cnt_r == pvd_pkg::CNT_MAX && eof_err_evt);
   c_stat: cover property (@(posedge clk_sys) disable iff (!arst_n) rd && addr == pvd_pkg::ADDR_EQ && opcode_r == pvd_pkg::OP_STAT);
   c_sd: cover property (@(posedge clk_sys) disable iff (!arst_n) sd_load_pulse);
   c_jab_sat: cover property (@(posedge clk_sys) disable iff (!arst_n) jab_cnt_r == pvd_pkg::CNT_MAX && jabber_evt);
   c_cz: cover property (@(posedge clk_sys) disable iff (!arst_n) cfg0_load_pulse);
endmodule : pvd_regs

//--- pvd_station.sv
// management station model driving the register port of the diagnostic bank
`timescale 1ns/100ps
module pvd_station (
   input wire logic clk_sys, // bus clock
   output logic [4:0] addr, // register address
   output logic [15:0] wdata, // write data
   output logic wr, // write strobe
   output logic rd, // read strobe
   input wire logic [15:0] rdata // read data, cycle after rd
);
   initial begin
      addr = 5'h00;
      wdata = 16'h0000;
      wr = 1'b0;
      rd = 1'b0;
   end

   task automatic write(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= (a == pvd_pkg::ADDR_LED) ? {13'h0000, d[2:0]} : d;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
      // released data lines must not look like the last word
      wdata <= ~d;
      #1;
   endtask : write

   task automatic eq_cmd(input logic [2:0] op, input logic [12:0] v);
      write(pvd_pkg::ADDR_EQ, {op, v});
   endtask : eq_cmd

   task automatic read(input logic [4:0] a, output logic [15:0] d);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask : read
endmodule : pvd_station

//--- pvd_regs_tb.sv
// self-checking bench for the diagnostic register bank
`timescale 1ns/100ps
module pvd_regs_tb;
   logic clk_sys, arst_n, wr, rd, eof_err_evt, jabber_evt, cfg0_load_pulse, sd_load_pulse;
   logic activity_led_n, link_led_n;
   logic [4:0] addr, sd_preset;
   logic [15:0] wdata, rdata, rv;
   logic [63:0] rnd;
   logic [12:0] op1;
   logic [12:0] w [3];
   logic [15:0] ex [2];
   pvd_pkg::pvd_det_t det;
   pvd_pkg::pvd_led_in_t led_in;
   pvd_pkg::pvd_cfg0_t cfg0;
   pvd_pkg::pvd_cfg1_t cfg1;
   pvd_pkg::pvd_cfg2_t cfg2;
   int miscompares, num_checks, n;

   pvd_regs pvd_regs_i (.clk_sys(clk_sys), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .eof_err_evt(eof_err_evt), .jabber_evt(jabber_evt), .det(det), .led_in(led_in),
      .cfg0(cfg0), .cfg1(cfg1), .cfg2(cfg2), .cfg0_load_pulse(cfg0_load_pulse),
      .sd_load_pulse(sd_load_pulse), .sd_preset(sd_preset), .activity_led_n(activity_led_n),
      .link_led_n(link_led_n));
   pvd_station pvd_station_i (.clk_sys(clk_sys), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : chk

   task automatic stop_test;
      if (miscompares == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : stop_test

   // reserved operand bits are kept at zero
   function automatic logic [12:0] mmask(input int op);
      return op == 1 ? 13'h1FDF : op == 2 ? 13'h07D1 : 13'h03F3;
   endfunction : mmask

   function automatic logic [1:0] led_exp(input logic [2:0] s, input pvd_pkg::pvd_led_in_t li);
      return ~{s[2] ? s[1] : ((s[0] ^ s[1]) ? li.speed : li.activity), s[2] ? s[0] : (s[0] ? li.collision : li.link)};
   endfunction : led_exp

   initial begin
      #790000;
      miscompares++;
      $display("unexpected %0t: run hung", $time);
      stop_test();
   end

   initial begin
      void'($urandom(80));
      arst_n = 1'b0;
      eof_err_evt = 1'b0;
      jabber_evt = 1'b0;
      det = '0;
      led_in = '0;
      miscompares = 0;
      num_checks = 0;
      repeat (4) @(posedge clk_sys);
      arst_n <= 1'b1;
      n = 1 + $urandom % 40;
      // back-to-back events on one line, every other cycle on the other
      for (int i = 0; i < 2 * n; i++) begin
         @(posedge clk_sys);
         eof_err_evt <= 1'b1;
         jabber_evt <= i[0];
      end
      @(posedge clk_sys);
      eof_err_evt <= 1'b0;
      jabber_evt <= 1'b0;
      ex[0] = 16'(2 * n);
      ex[1] = 16'(n);
      for (int c = 0; c < 2; c++) begin
         pvd_station_i.read(5'(24 + c), rv);
         chk(rv, ex[c]);
         pvd_station_i.read(5'(24 + c), rv);
         chk(rv, 16'h0000);
      end
      @(posedge clk_sys);
      eof_err_evt <= 1'b1;
      jabber_evt <= 1'b1;
      repeat (65540) @(posedge clk_sys);
      eof_err_evt <= 1'b0;
      jabber_evt <= 1'b0;
      pvd_station_i.read(pvd_pkg::ADDR_EOF_CNT, rv);
      chk(rv, pvd_pkg::CNT_MAX);
      pvd_station_i.read(pvd_pkg::ADDR_JAB_CNT, rv);
      chk(rv, pvd_pkg::CNT_MAX);
      pvd_station_i.write(pvd_pkg::ADDR_JAB_CNT, 16'h1234);
      pvd_station_i.read(pvd_pkg::ADDR_JAB_CNT, rv);
      chk(rv, 16'h0000);
      for (int k = 0; k < 4; k++) begin
         for (int op = 1; op < 4; op++) begin
            op1 = 13'($urandom) & mmask(op);
            if (op == 2) op1[8:7] = 2'(k);
            w[op - 1] = op1;
            pvd_station_i.eq_cmd(3'(op), op1);
            if (op == 1) chk({15'h0000, cfg0_load_pulse}, {15'h0000, op1[12]});
            if (op == 2) chk({15'h0000, sd_load_pulse}, {15'h0000, op1[6]});
         end
         chk({11'h000, sd_preset}, {11'h000, k == 0 ? pvd_pkg::SD_PRE0 : k == 1 ? pvd_pkg::SD_PRE1 :
            k == 2 ? pvd_pkg::SD_PRE2 : pvd_pkg::SD_PRE3});
         for (int op = 0; op < 8; op++) begin
            if (op inside {[1:3]}) continue;
            pvd_station_i.eq_cmd(3'(op), 13'($urandom % 2));
         end
         chk({3'h0, cfg0}, {3'h0, w[0]});
         chk({3'h0, cfg1}, {3'h0, w[1]});
         chk({3'h0, cfg2}, {3'h0, w[2]});
      end
      for (int s = 0; s < 4; s++) begin
         rnd = {$urandom, $urandom};
         @(posedge clk_sys);
         det <= rnd[59:0];
         pvd_station_i.eq_cmd(pvd_pkg::OP_STAT, 13'h0000);
         pvd_station_i.read(pvd_pkg::ADDR_EQ, rv);
         chk(rv, {2'b00, 3'b100, w[1][10:9], det.fsm_state, det.lock_adapt, det.sig_detect, det.squelch,
            det.coded_zero});
         pvd_station_i.eq_cmd(pvd_pkg::OP_JIT, 13'(s));
         pvd_station_i.read(pvd_pkg::ADDR_EQ, rv);
         chk(rv, s == 0 ? det.jitter[15:0] : s == 1 ? det.jitter[21:6] : det.jitter[26:11]);
         pvd_station_i.eq_cmd(pvd_pkg::OP_CLK, 13'(s % 2));
         pvd_station_i.read(pvd_pkg::ADDR_EQ, rv);
         chk(rv, s[0] ? det.clk_count[23:8] : det.clk_count[15:0]);
      end
      for (int s = 0; s < 16; s++) begin
         @(posedge clk_sys);
         led_in <= 4'($urandom);
         pvd_station_i.write(pvd_pkg::ADDR_LED, 16'(s));
         @(posedge clk_sys);
         #1;
         chk({14'h0000, activity_led_n, link_led_n}, {14'h0000, led_exp(3'(s), led_in)});
         pvd_station_i.read(pvd_pkg::ADDR_LED, rv);
         chk(rv, {13'h0000, 3'(s)});
      end
      pvd_station_i.read(5'h05, rv);
      chk(rv, 16'h0000);
      stop_test();
   end
endmodule : pvd_regs_tb
